// ---- core/panel_ctrl.sv ----
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Function
// - Seven general synchronous outputs carry line sync, frame sync, active flag or others.
// - Line and frame counters produce the local start point aligned to the timing clock.
// - Sync outputs switch at up and down points with half timing-clock resolution.
// - Async outputs follow flags that travel with each outgoing data word.
// - Two chip-select outputs address two separate panels.
// - Seven general async outputs serve as store, read, register select or others.
// - Each new async data word starts a fresh local start point.
// - Async generators toggle at up and down points at half-clock resolution.
// - Sync panel interface uses pixel clock, line sync, frame sync, active flag, data.
// - Sync controls are placed by offset, up and down from the start point.
// - A display access lasts a whole number of timing-clock cycles.
// - Pixel bus changes only at fixed points relative to the start point.
// - Pixel data bus is output only.
module panel_ctrl #(
   parameter int NUM_SYNC  = panel_ctrl_pkg::NUM_SYNC,
   parameter int NUM_ASYNC = panel_ctrl_pkg::NUM_ASYNC,
   parameter int DATA_W    = panel_ctrl_pkg::DATA_W
) (
   input  wire logic                                clock,
   input  wire logic                                reset_n,
   input  wire logic                                clockEnable,
   input  wire logic [panel_ctrl_pkg::ADDR_W-1:0]   address,
   input  wire logic                                read,
   input  wire logic                                write,
   input  wire logic [31:0]                         writedata,
   input  wire logic [3:0]                          byteenable,
   output      logic [31:0]                         readdata,
   output      logic                                waitrequest,
   output      logic                                panelPixelClock,
   output      logic [NUM_SYNC-1:0]                 syncPins,
   output      logic [NUM_ASYNC-1:0]                asyncPins,
   output      logic                                panel0SelectN,
   output      logic                                panel1SelectN,
   output      logic [DATA_W-1:0]                   panelPixelBus
);

   localparam int PW = panel_ctrl_pkg::POS_W;
   localparam int WW = panel_ctrl_pkg::WORD_W;

   // Byte-enable merge of a write into a stored word.
   function automatic logic [31:0] mergeBytes(input logic [31:0] oldV, input logic [31:0] newV,
                                              input logic [3:0] be);
      logic [31:0] r;
      r = oldV;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = newV[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Half-open window test shared by sync and async generators.
   function automatic logic inWindow(input logic [PW:0] pos, input logic [PW:0] start,
                                     input logic [PW:0] stop);
      return (pos >= start) && (pos < stop);
   endfunction

   // ---------------------------------------------------------------------------
   // Registers and state
   // ---------------------------------------------------------------------------
   logic [1:0]               ctrl_q;
   logic [NUM_SYNC-1:0]      pol_q;
   logic [PW-1:0]            lineLen_q;
   logic [PW-1:0]            frameLines_q;
   logic [PW-1:0]            asyncLen_q;
   logic [31:0]              sgen_q [NUM_SYNC];
   logic [31:0]              agen_q [NUM_ASYNC];
   logic [PW:0]              halfCnt_q;
   logic [PW-1:0]            lineIdx_q;
   panel_ctrl_pkg::async_state_e aState_q;
   logic [PW:0]              aCnt_q;
   logic [WW-1:0]            aWord_q;
   logic [WW-1:0]            bufMem_q [2];
   logic                     bufWr_q;
   logic                     bufRd_q;
   logic [1:0]               bufCount_q;

   // ---------------------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------------------
   wire         busReq     = read | write;
   wire         accept     = clockEnable & busReq & ~waitrequest;
   wire         wrAccept   = accept & write;
   wire [6:2]   wAddr      = address[6:2];
   wire [2:0]   genIdx     = address[4:2];
   wire         hitCtrl    = wAddr == panel_ctrl_pkg::OFF_CTRL[6:2];
   wire         hitPol     = wAddr == panel_ctrl_pkg::OFF_POL[6:2];
   wire         hitLine    = wAddr == panel_ctrl_pkg::OFF_LINE[6:2];
   wire         hitFrame   = wAddr == panel_ctrl_pkg::OFF_FRAME[6:2];
   wire         hitAlen    = wAddr == panel_ctrl_pkg::OFF_ALEN[6:2];
   wire         hitData    = wAddr == panel_ctrl_pkg::OFF_DATA[6:2];
   wire         hitStat    = wAddr == panel_ctrl_pkg::OFF_STAT[6:2];
   wire         hitSgen    = (address[6:5] == panel_ctrl_pkg::OFF_SGEN_HI) && (genIdx != 3'h7);
   wire         hitAgen    = (address[6:5] == panel_ctrl_pkg::OFF_AGEN_HI) && (genIdx != 3'h7);
   wire         bufFull    = bufCount_q == 2'h2;
   wire         bufValid   = bufCount_q != 2'h0;
   wire         push       = wrAccept & hitData;
   wire [WW-1:0] bufHead   = bufMem_q[bufRd_q];
   wire         syncEn     = ctrl_q[panel_ctrl_pkg::CTRL_SYNC_EN_BIT];
   wire         asyncMode  = ctrl_q[panel_ctrl_pkg::CTRL_ASYNC_BIT];

   // A data write waits while the buffer is full; that is the back-pressure to software.
   wire         canAnswer  = ~(write & hitData & bufFull);
   wire [31:0]  readMux    =
      hitCtrl  ? {30'h0, ctrl_q} :
      hitPol   ? {25'h0, pol_q} :
      hitLine  ? {22'h0, lineLen_q} :
      hitFrame ? {22'h0, frameLines_q} :
      hitAlen  ? {22'h0, asyncLen_q} :
      hitStat  ? {6'h0, lineIdx_q, 13'h0, (aState_q == panel_ctrl_pkg::A_ACCESS), bufCount_q} :
      hitSgen  ? sgen_q[genIdx] :
      hitAgen  ? agen_q[genIdx] : 32'h0;

   // Waitrequest drops one cycle after a request appears and rises again after the accept edge.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0;
      end else if (clockEnable) begin
         waitrequest <= ~(busReq & waitrequest & canAnswer);
         if (busReq & waitrequest & canAnswer) begin
            readdata <= readMux;
         end
      end
   end

   // Byte-enable merges of a write into each narrow register; bits above the field fall away.
   wire [31:0]  ctrlMerged  = mergeBytes({30'h0, ctrl_q}, writedata, byteenable);
   wire [31:0]  polMerged   = mergeBytes({25'h0, pol_q}, writedata, byteenable);
   wire [31:0]  lineMerged  = mergeBytes({22'h0, lineLen_q}, writedata, byteenable);
   wire [31:0]  frameMerged = mergeBytes({22'h0, frameLines_q}, writedata, byteenable);
   wire [31:0]  alenMerged  = mergeBytes({22'h0, asyncLen_q}, writedata, byteenable);

   // Control registers; a write lands only at the accept edge.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q       <= panel_ctrl_pkg::RST_CTRL;
         pol_q        <= panel_ctrl_pkg::RST_POL;
         lineLen_q    <= panel_ctrl_pkg::RST_LINE;
         frameLines_q <= panel_ctrl_pkg::RST_FRAME;
         asyncLen_q   <= panel_ctrl_pkg::RST_ALEN;
      end else if (wrAccept) begin
         if (hitCtrl)  ctrl_q       <= ctrlMerged[1:0];
         if (hitPol)   pol_q        <= polMerged[6:0];
         if (hitLine)  lineLen_q    <= lineMerged[9:0];
         if (hitFrame) frameLines_q <= frameMerged[9:0];
         if (hitAlen)  asyncLen_q   <= alenMerged[9:0];
      end
   end

   // ---------------------------------------------------------------------------
   // Two-entry data buffer
   // ---------------------------------------------------------------------------
   logic pop;

   // Pointers and count; a push and a pop in one cycle keep the count.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         bufWr_q    <= 1'b0;
         bufRd_q    <= 1'b0;
         bufCount_q <= 2'h0;
         bufMem_q[0] <= '0;
         bufMem_q[1] <= '0;
      end else if (clockEnable) begin
         if (push) begin
            bufMem_q[bufWr_q] <= writedata[WW-1:0];
            bufWr_q           <= ~bufWr_q;
         end
         if (pop) begin
            bufRd_q <= ~bufRd_q;
         end
         bufCount_q <= bufCount_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // ---------------------------------------------------------------------------
   // Synchronous timing base
   // ---------------------------------------------------------------------------
   // One system clock is half a timing clock, so a line of N timing clocks is 2N half slots.
   wire [PW:0]   lineHalves = {lineLen_q, 1'b0};
   wire          lastHalf   = halfCnt_q == (lineHalves - (PW+1)'(1));
   wire          lastLine   = lineIdx_q == (frameLines_q - PW'(1));
   logic [NUM_SYNC-1:0] syncRaw;

   // The counters restart from the local start point whenever sync timing is switched off.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         halfCnt_q <= '0;
         lineIdx_q <= '0;
      end else if (clockEnable) begin
         if (!syncEn) begin
            halfCnt_q <= '0;
            lineIdx_q <= '0;
         end else begin
            halfCnt_q <= lastHalf ? '0 : halfCnt_q + (PW+1)'(1);
            if (lastHalf) begin
               lineIdx_q <= lastLine ? '0 : lineIdx_q + PW'(1);
            end
         end
      end
   end

   // Each sync generator compares either the half-slot count or the line count with its window.
   genvar g;
   generate
      for (g = 0; g < NUM_SYNC; g++) begin : gSync
         wire [31:0] cfg   = sgen_q[g];
         wire [PW:0] pos   = cfg[panel_ctrl_pkg::GEN_MODE_BIT] ? {1'b0, lineIdx_q} : halfCnt_q;
         wire [PW:0] start = {1'b0, cfg[panel_ctrl_pkg::GEN_OFF_LSB +: PW]}
                           + {1'b0, cfg[panel_ctrl_pkg::GEN_UP_LSB +: PW]};
         wire [PW:0] stop  = {1'b0, cfg[panel_ctrl_pkg::GEN_OFF_LSB +: PW]}
                           + {1'b0, cfg[panel_ctrl_pkg::GEN_DN_LSB +: PW]};
         assign syncRaw[g] = syncEn & inWindow(pos, start, stop);

         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               sgen_q[g] <= panel_ctrl_pkg::RST_GEN;
            end else if (wrAccept && hitSgen && genIdx == 3'(g)) begin
               sgen_q[g] <= mergeBytes(sgen_q[g], writedata, byteenable);
            end
         end
      end
   endgenerate

   // Sync pins and pixel clock are registered, so every control lags its window by one clock.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         syncPins        <= '0;
         panelPixelClock <= 1'b0;
      end else if (clockEnable) begin
         syncPins        <= syncRaw ^ pol_q;
         panelPixelClock <= syncEn & ~halfCnt_q[0];
      end
   end

   // ---------------------------------------------------------------------------
   // Asynchronous access engine
   // ---------------------------------------------------------------------------
   // An access length of zero is stretched to one timing clock rather than dropped.
   wire [PW:0]  aHalves  = (asyncLen_q == '0) ? (PW+1)'(panel_ctrl_pkg::PTC_DIV)
                                              : {asyncLen_q, 1'b0};
   wire         aActive  = aState_q == panel_ctrl_pkg::A_ACCESS;
   wire         aEnd     = aActive && (aCnt_q == aHalves - (PW+1)'(1));
   wire         asyncPop = (aState_q == panel_ctrl_pkg::A_IDLE) & asyncMode & bufValid;
   // Pixels leave only in the last half of a timing clock, so the bus moves on whole-clock marks.
   wire         syncPop  = syncEn & ~asyncMode & halfCnt_q[0]
                         & syncRaw[panel_ctrl_pkg::ACT_GEN] & bufValid;
   assign pop = asyncPop | syncPop;
   logic [NUM_ASYNC-1:0] asyncRaw;

   // Loading a word restarts the access counter: the local start point for async pins.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         aState_q <= panel_ctrl_pkg::A_IDLE;
         aCnt_q   <= '0;
         aWord_q  <= '0;
      end else if (clockEnable) begin
         case (aState_q)
            panel_ctrl_pkg::A_IDLE: begin
               if (asyncPop) begin
                  aState_q <= panel_ctrl_pkg::A_ACCESS;
                  aCnt_q   <= '0;
                  aWord_q  <= bufHead;
               end
            end
            panel_ctrl_pkg::A_ACCESS: begin
               aCnt_q <= aCnt_q + (PW+1)'(1);
               if (aEnd) begin
                  aState_q <= panel_ctrl_pkg::A_IDLE;
               end
            end
            default: begin
               aState_q <= panel_ctrl_pkg::A_IDLE;
            end
         endcase
      end
   end

   // Each async pin pulses only when its flag rides with the current word.
   genvar a;
   generate
      for (a = 0; a < NUM_ASYNC; a++) begin : gAsync
         wire [31:0] cfg = agen_q[a];
         assign asyncRaw[a] = aActive & aWord_q[panel_ctrl_pkg::DATA_FLAG_LSB + a]
                            & inWindow(aCnt_q, {1'b0, cfg[0 +: PW]}, {1'b0, cfg[PW +: PW]});

         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               agen_q[a] <= panel_ctrl_pkg::RST_GEN;
            end else if (wrAccept && hitAgen && genIdx == 3'(a)) begin
               agen_q[a] <= mergeBytes(agen_q[a], writedata, byteenable);
            end
         end
      end
   endgenerate

   // Pins, selects and the output-only pixel bus, all straight from flops.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         asyncPins     <= '0;
         panel0SelectN <= 1'b1;
         panel1SelectN <= 1'b1;
         panelPixelBus <= '0;
      end else if (clockEnable) begin
         asyncPins     <= asyncRaw;
         panel0SelectN <= ~(aActive & ~aWord_q[panel_ctrl_pkg::DATA_CS_BIT]);
         panel1SelectN <= ~(aActive & aWord_q[panel_ctrl_pkg::DATA_CS_BIT]);
         if (pop) begin
            panelPixelBus <= bufHead[DATA_W-1:0];
         end
      end
   end

   // ---------------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------------
   a_line_wrap: assert property (@(posedge clock) disable iff (!reset_n)
      clockEnable && syncEn && lastHalf && lastLine |=> halfCnt_q == '0 && lineIdx_q == '0)
      else $error("Line and frame counters did not wrap together.");

   a_half_step: assert property (@(posedge clock) disable iff (!reset_n)
      clockEnable && syncEn && !lastHalf && !$changed(ctrl_q) |=> halfCnt_q == $past(halfCnt_q) + 1)
      else $error("Half-slot counter skipped a step.");

   a_sync_polarity: assert property (@(posedge clock) disable iff (!reset_n)
      clockEnable && !syncEn |=> syncPins == $past(pol_q))
      else $error("Idle sync pins do not show their inactive level.");

   a_async_start: assert property (@(posedge clock) disable iff (!reset_n)
      clockEnable && asyncPop |=> aActive && aCnt_q == '0 && aWord_q == $past(bufHead))
      else $error("Async access did not start from a fresh start point.");

   a_access_whole: assert property (@(posedge clock) disable iff (!reset_n)
      clockEnable && aEnd |-> aCnt_q[0])
      else $error("Async access ended on a half clock.");

   a_select_excl: assert property (@(posedge clock) disable iff (!reset_n)
      !(~panel0SelectN && ~panel1SelectN))
      else $error("Both panel selects are active.");

   a_flag_gates: assert property (@(posedge clock) disable iff (!reset_n)
      clockEnable && !aWord_q[panel_ctrl_pkg::DATA_FLAG_LSB] |=> !asyncPins[0])
      else $error("Async pin moved without its data flag.");

   a_pixel_hold: assert property (@(posedge clock) disable iff (!reset_n)
      clockEnable && !pop |=> $stable(panelPixelBus))
      else $error("Pixel bus moved without a buffered word.");

   a_pixel_clock: assert property (@(posedge clock) disable iff (!reset_n)
      clockEnable && syncEn |=> panelPixelClock == !$past(halfCnt_q[0]))
      else $error("Pixel clock not aligned to the timing base.");

   a_wait_full: assert property (@(posedge clock) disable iff (!reset_n)
      clockEnable && write && hitData && bufFull && waitrequest |=> waitrequest)
      else $error("Data write answered while the buffer was full.");

   c_async_access: cover property (@(posedge clock) disable iff (!reset_n) aEnd);
   c_frame_wrap:   cover property (@(posedge clock) disable iff (!reset_n) lastHalf && lastLine && syncEn);
   c_buffer_full:  cover property (@(posedge clock) disable iff (!reset_n) bufFull && write && hitData);
   c_sync_pixel:   cover property (@(posedge clock) disable iff (!reset_n) syncPop);

endmodule // panel_ctrl

// ---- core/panel_ctrl_pkg.sv ----
package panel_ctrl_pkg;

   // ---------------------------------------------------------------------------
   // Timing base
   // ---------------------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 100;   // System clock period in nanoseconds.
   localparam int PTC_PERIOD_NS   = 200;   // One panel timing clock period in nanoseconds.
   // System clocks per panel timing clock; one system clock is half a panel timing clock.
   localparam int PTC_DIV         = (PTC_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   // ---------------------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------------------
   localparam int NUM_SYNC   = 7;
   localparam int NUM_ASYNC  = 7;
   localparam int POS_W      = 10;
   localparam int DATA_W     = 16;
   localparam int ADDR_W     = 7;
   localparam int ACT_GEN    = 2;          // Generator whose window paces pixel data.

   // ---------------------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------------------
   localparam logic [6:0] OFF_CTRL  = 7'h00;
   localparam logic [6:0] OFF_POL   = 7'h04;
   localparam logic [6:0] OFF_LINE  = 7'h08;
   localparam logic [6:0] OFF_FRAME = 7'h0C;
   localparam logic [6:0] OFF_ALEN  = 7'h10;
   localparam logic [6:0] OFF_DATA  = 7'h14;
   localparam logic [6:0] OFF_STAT  = 7'h18;
   localparam logic [1:0] OFF_SGEN_HI = 2'h1;   // 0x20 + 4*i, i = 0..6.
   localparam logic [1:0] OFF_AGEN_HI = 2'h2;   // 0x40 + 4*i, i = 0..6.

   // ---------------------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------------------
   localparam int CTRL_SYNC_EN_BIT = 0;
   localparam int CTRL_ASYNC_BIT   = 1;
   localparam int GEN_OFF_LSB      = 0;
   localparam int GEN_UP_LSB       = 10;
   localparam int GEN_DN_LSB       = 20;
   localparam int GEN_MODE_BIT     = 30;
   localparam int DATA_CS_BIT      = 16;
   localparam int DATA_FLAG_LSB    = 17;
   localparam int WORD_W           = DATA_FLAG_LSB + NUM_ASYNC;
   localparam int STAT_BUSY_BIT    = 2;
   localparam int STAT_LINE_LSB    = 16;

   // ---------------------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------------------
   localparam logic [1:0]  RST_CTRL  = 2'h0;
   localparam logic [6:0]  RST_POL   = 7'h00;
   localparam logic [9:0]  RST_LINE  = 10'h064;
   localparam logic [9:0]  RST_FRAME = 10'h00A;
   localparam logic [9:0]  RST_ALEN  = 10'h004;
   localparam logic [31:0] RST_GEN   = 32'h0000_0000;

   typedef enum logic [1:0] {
      A_IDLE   = 2'b01,
      A_ACCESS = 2'b10
   } async_state_e;

endpackage

// ---- dv/panel_model.sv ----
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Panel that latches each new pixel word
// ---------------------------------------------------------------------------
module panel_model (
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic [15:0] pixelBus
);
   logic [31:0] words [8];
   logic [15:0] lastWord;
   int          count;

   // A word is taken when the bus changes, so a repeated word goes unseen.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lastWord <= 16'h0000;
         count    <= 0;
      end else if (pixelBus !== lastWord && count < 8) begin
         words[count] <= {16'h0000, pixelBus};
         lastWord     <= pixelBus;
         count        <= count + 1;
      end
   end
endmodule // panel_model

// ---- dv/testbench.sv ----
`timescale 1ns/1ps

module testbench;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        enable = 1'b1;
   logic [6:0]  address = 7'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        panelPixelClock;
   logic [6:0]  syncPins;
   logic [6:0]  asyncPins;
   logic        panel0SelectN;
   logic        panel1SelectN;
   logic [15:0] panelPixelBus;
   logic [31:0] rd;
   int          err_count = 0;
   int          checks = 0;
   int          nSync, nClk, nSel0, nSel1, nPin;
   logic [6:0]  regAddr [6] = '{7'h00, 7'h04, 7'h08, 7'h0C, 7'h10, 7'h60};
   logic [31:0] regRst [6] = '{32'h0, 32'h0, 32'h64, 32'h0A, 32'h04, 32'h0};

   // ------------------------------------------------------------------------
   // Clock, design and panel
   // ------------------------------------------------------------------------
   always #50 clock = ~clock;

   panel_ctrl uut (.clock(clock), .reset_n(reset_n), .clockEnable(enable), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
      .waitrequest(waitrequest), .panelPixelClock(panelPixelClock), .syncPins(syncPins),
      .asyncPins(asyncPins), .panel0SelectN(panel0SelectN), .panel1SelectN(panel1SelectN),
      .panelPixelBus(panelPixelBus));

   panel_model panel (.clock(clock), .reset_n(reset_n), .pixelBus(panelPixelBus));

   // ------------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------------
   // One Avalon access; an idle edge follows so the next call never drives twice in a step.
   task automatic bus_cycle(input logic [6:0] a, input logic wr, input logic [31:0] d);
      address   <= a;
      read      <= !wr;
      write     <= wr;
      writedata <= d;
      // Only the watchdog ends a wait that never gets its answer.
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge clock);
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Counts, over n clocks, how long sync pin 0, the pixel clock and async pin 0 sit high and each select sits low.
   task automatic meas(input int n);
      nSync = 0;
      nClk  = 0;
      nSel0 = 0;
      nSel1 = 0;
      nPin  = 0;
      repeat (n) begin
         @(posedge clock);
         nSync += (syncPins[0] === 1'b1);
         nClk  += (panelPixelClock === 1'b1);
         nSel0 += (panel0SelectN === 1'b0);
         nSel1 += (panel1SelectN === 1'b0);
         nPin  += (asyncPins[0] === 1'b1);
      end
   endtask

   task automatic test_done();
      if (err_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------------
   // Registers, sync windows, pixel path through the buffer, then async accesses.
   initial begin
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      bus_cycle(7'h60, 1'b1, 32'hFFFF_FFFF);
      foreach (regAddr[i]) begin
         bus_cycle(regAddr[i], 1'b0, 32'h0);
         chk("register reset", regRst[i], rd);
      end
      bus_cycle(7'h08, 1'b1, 32'h8);
      bus_cycle(7'h20, 1'b1, 32'h0040_0000);
      bus_cycle(7'h00, 1'b1, 32'h1);
      meas(16);
      chk("sync window", 4, nSync);
      chk("pixel clock", 8, nClk);
      bus_cycle(7'h04, 1'b1, 32'h1);
      meas(16);
      chk("inverted window", 12, nSync);
      // With the clock enable low every flop holds, so each pin count is all or nothing.
      enable <= 1'b0;
      @(posedge clock);
      meas(16);
      chk("frozen pixel clock", 0, nClk % 16);
      chk("frozen sync pin", 0, nSync % 16);
      enable <= 1'b1;
      // With sync off nothing drains, so two pushes fill the buffer.
      bus_cycle(7'h00, 1'b1, 32'h0);
      bus_cycle(7'h14, 1'b1, 32'h0000_1234);
      bus_cycle(7'h14, 1'b1, 32'h0000_ABCD);
      bus_cycle(7'h18, 1'b0, 32'h0);
      chk("buffer count", 32'h2, rd & 32'h3);
      bus_cycle(7'h28, 1'b1, 32'h0100_0000);
      bus_cycle(7'h00, 1'b1, 32'h1);
      repeat (40) @(posedge clock);
      chk("pixel word 0", 32'h1234, panel.words[0]);
      chk("pixel word 1", 32'hABCD, panel.words[1]);
      bus_cycle(7'h00, 1'b1, 32'h2);
      bus_cycle(7'h10, 1'b1, 32'h2);
      bus_cycle(7'h40, 1'b1, 32'h0000_0C01);
      fork
         meas(30);
         bus_cycle(7'h14, 1'b1, 32'h0003_5A5A);
      join
      chk("panel1 select", 4, nSel1);
      chk("panel0 select", 0, nSel0);
      chk("async pin", 2, nPin);
      chk("async word", 32'h5A5A, panel.words[2]);
      fork
         meas(30);
         bus_cycle(7'h14, 1'b1, 32'h0000_0001);
      join
      chk("async flag off", 0, nPin);
      chk("panel0 access", 4, nSel0);
      test_done();
   end

   // Watchdog well beyond the few hundred clocks the tests need.
   initial begin
      #1000000;
      err_count++;
      test_done();
   end
endmodule // testbench
